// ==== verilog/upf_pkg.sv ====
// package: constants, structs and states of the usb parallel fifo port
package upf_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CLK_MHZ = 125;
  localparam int WAKE_HOLD_MS = 20;
  // least time rounds up; 20 ms at 125 MHz is an exact count
  localparam int WAKE_HOLD_CYCLES = (WAKE_HOLD_MS * 1000 * CLK_MHZ + 0) / 1;
  localparam int WAKE_CNT_W = 22;
  localparam logic [1:0] CFG_PIN_RST = 2'h0;
  localparam logic [1:0] CFG_SEL_TXE = 2'h1;
  localparam logic [1:0] CFG_SEL_RXF = 2'h2;
  localparam logic [1:0] CFG_SEL_SUSP = 2'h3;

  typedef struct packed {
    logic rd_n;
    logic wr;
    logic send_now_wake_n;
    logic rx_avail_in;
  } upf_pins_t;

  // idle levels of the strobes; synchroniser stages restart here so reset makes no false edge
  localparam upf_pins_t PINS_IDLE = '{rd_n: 1'b1, wr: 1'b0, send_now_wake_n: 1'b1, rx_avail_in: 1'b1};

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic valid;
  } upf_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } upf_state_t;
endpackage : upf_pkg

// ==== verilog/upf_fifo.sv ====
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module upf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } upf_fifo_state_t;

  upf_fifo_state_t s_reg, s_next;
  logic push, pop;

  assign in_ready = s_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_reg.cnt != '0;
  assign out_data = s_reg.mem[s_reg.rp];
  assign level = s_reg.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : upf_fifo

// ==== verilog/upf_port.sv ====
// device side of the asynchronous eight-bit parallel fifo port
`timescale 1ns/1ps
module upf_port
  import upf_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  input wire logic RESET_PIN_N,
  // parallel bus pins
  input wire logic [upf_pkg::DATA_W-1:0] FIFO_DATA_IN,
  output logic [upf_pkg::DATA_W-1:0] FIFO_DATA_OUT,
  output logic FIFO_DATA_OE,
  input wire logic RD_N,
  input wire logic WR,
  // flags
  output logic TX_SPACE_N,
  output logic TX_SPACE_OE,
  input wire logic RX_AVAIL_N_IN,
  output logic RX_AVAIL_N,
  output logic RX_AVAIL_OE,
  input wire logic SEND_NOW_WAKE_N,
  // configurable pins
  output logic CONFIG_PIN_5,
  output logic CONFIG_PIN_6,
  // usb core side: receive stream in
  input wire logic RX_VALID,
  input wire logic [upf_pkg::DATA_W-1:0] RX_DATA,
  output logic RX_READY,
  // usb core side: transmit stream out
  output logic TX_VALID,
  output logic [upf_pkg::DATA_W-1:0] TX_DATA,
  input wire logic TX_READY,
  output logic TX_FLUSH,
  // suspend, wakeup and config memory
  input wire logic POWER_ENABLE_N,
  input wire logic REMOTE_WAKE_EN,
  input wire logic [1:0] CFG_PIN5_SEL,
  input wire logic [1:0] CFG_PIN6_SEL,
  output logic RESUME_REQ
);
  import upf_pkg::*;

  typedef struct packed {
    upf_pins_t s1;
    upf_pins_t s2;
    upf_pins_t s3;
    logic [1:0] rst_sync;
    upf_state_t st;
    logic [DATA_W-1:0] dout;
    logic dout_oe;
    logic rd_pop;
    logic wr_push;
    logic [DATA_W-1:0] wr_byte;
    logic [DATA_W-1:0] bus_s1;
    logic [DATA_W-1:0] bus_s2;
    logic txs_n;
    logic txs_oe;
    logic rxa_n;
    logic rxa_oe;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic resume;
    logic flush;
    logic cfg5;
    logic cfg6;
  } upf_top_state_t;

  upf_top_state_t s_reg, s_next;
  logic rx_in_ready, rx_out_valid, tx_in_ready, tx_out_valid;
  logic [DATA_W-1:0] rx_out_data, tx_out_data;
  logic [PTR_W:0] rx_level, tx_level;
  logic dev_reset, suspended, wake_input;

  function automatic logic cfg_mux(input logic [1:0] sel, input logic txe, input logic rxf, input logic susp);
    unique case (sel)
      CFG_SEL_TXE: cfg_mux = txe;
      CFG_SEL_RXF: cfg_mux = rxf;
      CFG_SEL_SUSP: cfg_mux = susp;
      default: cfg_mux = CFG_PIN_RST[0];
    endcase
  endfunction : cfg_mux

  // strobe edges are judged on the two older synchroniser stages only
  function automatic logic fell_edge(input logic older, input logic newer);
    fell_edge = older && !newer;
  endfunction : fell_edge

  // one capture of the asynchronous pins into the first synchroniser stage
  function automatic upf_pins_t sample_pins(input logic rd_n, input logic wr, input logic snw_n, input logic rxa_in);
    sample_pins.rd_n = rd_n;
    sample_pins.wr = wr;
    sample_pins.send_now_wake_n = snw_n;
    sample_pins.rx_avail_in = rxa_in;
  endfunction : sample_pins

  // space counts a push still in flight, so a full fifo is never offered one more write
  function automatic logic tx_space_flag(input logic ready, input logic push_pending);
    tx_space_flag = !(ready && !push_pending);
  endfunction : tx_space_flag

  // a byte already being read is no longer announced, which avoids a double read
  function automatic logic rx_avail_flag(input logic valid, input logic pop_pending, input logic reading);
    rx_avail_flag = !(valid && !pop_pending && !reading);
  endfunction : rx_avail_flag

  // state after either reset: flags float, strobes at idle levels
  function automatic upf_top_state_t idle_state(input logic [1:0] sync);
    idle_state = '0;
    idle_state.s1 = PINS_IDLE;
    idle_state.s2 = PINS_IDLE;
    idle_state.s3 = PINS_IDLE;
    idle_state.rst_sync = sync;
    idle_state.st = ST_IDLE;
    idle_state.dout = '0;
    idle_state.dout_oe = 1'b0;
    idle_state.rd_pop = 1'b0;
    idle_state.wr_push = 1'b0;
    idle_state.wr_byte = '0;
    idle_state.bus_s1 = '0;
    idle_state.bus_s2 = '0;
    idle_state.txs_n = 1'b1;
    idle_state.txs_oe = 1'b0;
    idle_state.rxa_n = 1'b1;
    idle_state.rxa_oe = 1'b0;
    idle_state.wake_cnt = '0;
    idle_state.resume = 1'b0;
    idle_state.flush = 1'b0;
    idle_state.cfg5 = 1'b0;
    idle_state.cfg6 = 1'b0;
  endfunction : idle_state

  // reset pin is asynchronous to CLK, so it is synchronised first
  assign dev_reset = RESET || !s_reg.rst_sync[1];
  // power-enable indicator reads 1 while the host has the bus suspended
  assign suspended = POWER_ENABLE_N;
  assign wake_input = REMOTE_WAKE_EN && suspended;

  // receive buffer: core fills it, bus reads drain it
  upf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(PTR_W)) u_rx_fifo (
    .clk(CLK),
    .reset(dev_reset),
    .in_valid(RX_VALID),
    .in_ready(rx_in_ready),
    .in_data(RX_DATA),
    .out_valid(rx_out_valid),
    .out_ready(s_reg.rd_pop),
    .out_data(rx_out_data),
    .level(rx_level)
  );

  // transmit buffer: bus writes fill it, core drains it and may stall
  upf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(PTR_W)) u_tx_fifo (
    .clk(CLK),
    .reset(dev_reset),
    .in_valid(s_reg.wr_push),
    .in_ready(tx_in_ready),
    .in_data(s_reg.wr_byte),
    .out_valid(tx_out_valid),
    .out_ready(TX_READY),
    .out_data(tx_out_data),
    .level(tx_level)
  );

  assign RX_READY = rx_in_ready;
  assign TX_VALID = tx_out_valid;
  assign TX_DATA = tx_out_data;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = sample_pins(RD_N, WR, SEND_NOW_WAKE_N, RX_AVAIL_N_IN);
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.bus_s1 = FIFO_DATA_IN;
    s_next.bus_s2 = s_reg.bus_s1;
    s_next.rst_sync = {s_reg.rst_sync[0], RESET_PIN_N};
    s_next.rd_pop = 1'b0;
    s_next.wr_push = 1'b0;
    s_next.resume = 1'b0;
    s_next.flush = 1'b0;
    unique case (s_reg.st)
      ST_IDLE: begin
        // read wins if both strobes fall together; partner must avoid it
        if (fell_edge(s_reg.s3.rd_n, s_reg.s2.rd_n)) begin
          s_next.st = ST_READ;
          s_next.dout = rx_out_data;
          s_next.dout_oe = 1'b1;
          s_next.rd_pop = rx_out_valid && !wake_input;
        end else if (fell_edge(s_reg.s3.wr, s_reg.s2.wr)) begin
          s_next.wr_push = 1'b1;
          s_next.wr_byte = s_reg.bus_s2;
          s_next.st = ST_WRITE;
        end
      end
      ST_READ: begin
        if (s_reg.s2.rd_n) begin
          s_next.dout_oe = 1'b0;
          s_next.st = ST_IDLE;
        end
      end
      ST_WRITE: begin
        s_next.st = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
        s_next.dout_oe = 1'b0;
      end
    endcase
    // flags; space counts a push still in flight
    s_next.txs_n = tx_space_flag(tx_in_ready, s_reg.wr_push);
    s_next.txs_oe = 1'b1;
    s_next.rxa_n = rx_avail_flag(rx_out_valid, s_reg.rd_pop, s_reg.st == ST_READ);
    s_next.rxa_oe = !wake_input;
    // remote wake: pin held low 20 ms, counted on synchronised level
    if (wake_input && !s_reg.s2.rx_avail_in) begin
      if (s_reg.wake_cnt == WAKE_CNT_W'(WAKE_HOLD_CYCLES - 1)) begin
        s_next.resume = 1'b1;
        s_next.wake_cnt = '0;
      end else begin
        s_next.wake_cnt = s_reg.wake_cnt + 1'b1;
      end
    end else begin
      s_next.wake_cnt = '0;
    end
    // send-now: falling edge flushes, or wakes a suspended host
    if (fell_edge(s_reg.s3.send_now_wake_n, s_reg.s2.send_now_wake_n)) begin
      if (suspended) begin
        s_next.resume = 1'b1;
      end else begin
        s_next.flush = 1'b1;
      end
    end
    s_next.cfg5 = cfg_mux(CFG_PIN5_SEL, s_reg.txs_n, s_reg.rxa_n, suspended);
    s_next.cfg6 = cfg_mux(CFG_PIN6_SEL, s_reg.txs_n, s_reg.rxa_n, suspended);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_reg <= idle_state(2'h0);
    end else if (!s_reg.rst_sync[1]) begin
      // pin reset: flags float, synchroniser keeps running
      s_reg <= idle_state(s_next.rst_sync);
    end else begin
      s_reg <= s_next;
    end
  end

  assign FIFO_DATA_OUT = s_reg.dout;
  assign FIFO_DATA_OE = s_reg.dout_oe;
  assign TX_SPACE_N = s_reg.txs_n;
  assign TX_SPACE_OE = s_reg.txs_oe;
  assign RX_AVAIL_N = s_reg.rxa_n;
  assign RX_AVAIL_OE = s_reg.rxa_oe;
  assign CONFIG_PIN_5 = s_reg.cfg5;
  assign CONFIG_PIN_6 = s_reg.cfg6;
  assign TX_FLUSH = s_reg.flush;
  assign RESUME_REQ = s_reg.resume;
endmodule : upf_port

// ==== verification/upf_port_monitor.sv ====
// concurrent checks on the parallel fifo port pins
`timescale 1ns/1ps
module upf_port_monitor (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic RD_N,
  input wire logic WR,
  input wire logic TX_SPACE_N,
  input wire logic TX_SPACE_OE,
  input wire logic RX_AVAIL_OE,
  input wire logic FIFO_DATA_OE,
  input wire logic TX_VALID,
  input wire logic SEND_NOW_WAKE_N,
  input wire logic POWER_ENABLE_N,
  input wire logic REMOTE_WAKE_EN,
  input wire logic TX_FLUSH,
  input wire logic RESUME_REQ,
  input wire logic [1:0] CFG_PIN5_SEL,
  input wire logic CONFIG_PIN_5
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // reset itself is the cause here, so this one must not be disabled by it
  chk_flags_float: assert property (disable iff (1'b0) RESET |=> !TX_SPACE_OE && !RX_AVAIL_OE)
    else $error("flag pins driven in reset");
  chk_drive_gate: assert property ($rose(FIFO_DATA_OE) |-> !RD_N)
    else $error("bus driven without read strobe");
  chk_bus_release: assert property (RD_N [*5] |-> !FIFO_DATA_OE)
    else $error("bus not released");
  chk_read_answer: assert property ($fell(RD_N) |-> ##[2:6] FIFO_DATA_OE)
    else $error("read strobe not answered");
  chk_write_push: assert property ($fell(WR) && !TX_SPACE_N |-> ##[2:7] TX_VALID)
    else $error("written byte not queued");
  chk_flush_pulse: assert property ($fell(SEND_NOW_WAKE_N) && !POWER_ENABLE_N |-> ##[1:6] TX_FLUSH)
    else $error("no flush");
  chk_wake_pulse: assert property ($fell(SEND_NOW_WAKE_N) && POWER_ENABLE_N |-> ##[1:6] RESUME_REQ)
    else $error("no wakeup");
  chk_rx_input: assert property ((POWER_ENABLE_N && REMOTE_WAKE_EN) [*2] |-> !RX_AVAIL_OE)
    else $error("rx pin still driven in suspend");
  chk_cfg_low: assert property ((CFG_PIN5_SEL == 2'h0) [*2] |-> !CONFIG_PIN_5)
    else $error("config pin not low");
endmodule : upf_port_monitor
bind upf_port upf_port_monitor upf_port_monitor_inst (.CLK, .RESET, .RD_N, .WR, .TX_SPACE_N, .TX_SPACE_OE,
  .RX_AVAIL_OE, .FIFO_DATA_OE, .TX_VALID, .SEND_NOW_WAKE_N, .POWER_ENABLE_N, .REMOTE_WAKE_EN, .TX_FLUSH,
  .RESUME_REQ, .CFG_PIN5_SEL, .CONFIG_PIN_5);

// ==== verification/upf_host_model.sv ====
// model of the external controller strobing the port
`timescale 1ns/1ps
module upf_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  output logic rd_n,
  output logic wr,
  output logic [7:0] data_in
);
  initial begin
    rd_n = 1'b1;
    wr = 1'b0;
    data_in = 8'h00;
  end
  // one strobe at a time, so the shared bus never sees both directions
  task automatic rd(output logic [7:0] d);
    rd_n <= 1'b0;
    repeat (7) @(posedge clk);
    d = data_out;
    rd_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : rd
  task automatic wr_byte(input logic [7:0] d);
    data_in <= d;
    wr <= 1'b1;
    repeat (5) @(posedge clk);
    wr <= 1'b0;
    repeat (6) @(posedge clk);
    // released bus shows the inverse so a late sample cannot pass by luck
    data_in <= ~d;
    @(posedge clk);
  endtask : wr_byte
endmodule : upf_host_model

// ==== verification/upf_port_tb.sv ====
// self-checking bench of the parallel fifo port
`timescale 1ns/1ps
module upf_port_tb;
  import upf_pkg::*;
  logic CLK, RESET, RESET_PIN_N, RD_N, WR, SEND_NOW_WAKE_N, RX_VALID, TX_READY, RX_AVAIL_N_IN, RX_READY;
  logic POWER_ENABLE_N, REMOTE_WAKE_EN, TX_VALID, TX_FLUSH, RESUME_REQ, FIFO_DATA_OE, TX_SPACE_N;
  logic TX_SPACE_OE, RX_AVAIL_N, RX_AVAIL_OE, CONFIG_PIN_5, CONFIG_PIN_6;
  logic [1:0] CFG_PIN5_SEL, CFG_PIN6_SEL;
  logic [7:0] FIFO_DATA_OUT, host_data, RX_DATA, TX_DATA, d, sent[$], seen[$];
  int fails = 0, checks = 0, cyc = 0, seed = 62812, n;
  wire [7:0] bus = FIFO_DATA_OE ? FIFO_DATA_OUT : host_data;
  upf_port upf_port_inst (.CLK, .RESET, .RESET_PIN_N, .FIFO_DATA_IN(bus), .FIFO_DATA_OUT, .FIFO_DATA_OE,
    .RD_N, .WR, .TX_SPACE_N, .TX_SPACE_OE, .RX_AVAIL_N_IN, .RX_AVAIL_N, .RX_AVAIL_OE, .SEND_NOW_WAKE_N,
    .CONFIG_PIN_5, .CONFIG_PIN_6, .RX_VALID, .RX_DATA, .RX_READY, .TX_VALID, .TX_DATA, .TX_READY,
    .TX_FLUSH, .POWER_ENABLE_N, .REMOTE_WAKE_EN, .CFG_PIN5_SEL, .CFG_PIN6_SEL, .RESUME_REQ);
  upf_host_model upf_host_model_inst (.clk(CLK), .data_out(bus), .rd_n(RD_N), .wr(WR), .data_in(host_data));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v, input string what);
    checks++;
    if (seen_v !== exp_v) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // with the rx fifo empty, only the rx flag selection reads high
  function automatic logic pin_exp(input logic [1:0] s);
    return s == CFG_SEL_RXF;
  endfunction : pin_exp
  always @(posedge CLK) begin
    cyc++;
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) seen.push_back(TX_DATA);
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    {RESET, RESET_PIN_N, SEND_NOW_WAKE_N, RX_AVAIL_N_IN} = 4'hf;
    {RX_VALID, TX_READY, POWER_ENABLE_N, REMOTE_WAKE_EN} = 4'h0;
    {CFG_PIN5_SEL, CFG_PIN6_SEL, RX_DATA} = 12'h000;
    repeat (3) @(posedge CLK);
    check(TX_SPACE_OE, 1'b0, "tx flag oe in reset");
    check(RX_AVAIL_OE, 1'b0, "rx flag oe in reset");
    RESET <= 1'b0;
    repeat (3) @(posedge CLK);
    for (int s = 0; s < 4; s++) begin
      CFG_PIN5_SEL <= 2'(s);
      CFG_PIN6_SEL <= 2'(3 - s);
      repeat (3) @(posedge CLK);
      check(CONFIG_PIN_5, pin_exp(2'(s)), "pin5");
      check(CONFIG_PIN_6, pin_exp(2'(3 - s)), "pin6");
    end
    n = 3 + $unsigned($random(seed)) % 8;
    repeat (n) begin
      RX_VALID <= 1'b1;
      RX_DATA <= 8'($random(seed));
      @(posedge CLK);
      sent.push_back(RX_DATA);
    end
    RX_VALID <= 1'b0;
    repeat (4) @(posedge CLK);
    check(RX_AVAIL_N, 1'b0, "rx flag with data");
    while (sent.size() > 0) begin
      upf_host_model_inst.rd(d);
      check(d, sent.pop_front(), "read byte");
    end
    check(RX_AVAIL_N, 1'b1, "rx flag empty");
    // core stalled so the writes pile up until the flag refuses more
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      check(TX_SPACE_N, 1'b0, "tx flag room");
      d = 8'($random(seed));
      sent.push_back(d);
      upf_host_model_inst.wr_byte(d);
    end
    check(TX_SPACE_N, 1'b1, "tx flag full");
    TX_READY <= 1'b1;
    repeat (40) @(posedge CLK);
    check(8'(seen.size()), 8'(FIFO_DEPTH), "tx count");
    while (seen.size() > 0) check(seen.pop_front(), sent.pop_front(), "tx byte");
    for (int s = 0; s < 2; s++) begin
      POWER_ENABLE_N <= s[0];
      REMOTE_WAKE_EN <= s[0];
      repeat (4) @(posedge CLK);
      SEND_NOW_WAKE_N <= 1'b0;
      n = 0;
      repeat (8) begin
        @(posedge CLK);
        n += s ? RESUME_REQ : TX_FLUSH;
      end
      check(8'(n), 8'h01, "send now pulse");
      SEND_NOW_WAKE_N <= 1'b1;
    end
    check(RX_AVAIL_OE, 1'b0, "rx pin input in suspend");
    POWER_ENABLE_N <= 1'b0;
    REMOTE_WAKE_EN <= 1'b0;
    RESET_PIN_N <= 1'b0;
    repeat (5) @(posedge CLK);
    check(TX_SPACE_OE, 1'b0, "reset pin");
    RESET_PIN_N <= 1'b1;
    repeat (4) @(posedge CLK);
    report_and_stop();
  end
endmodule : upf_port_tb
